// ---- testbench/scan_port_address_connect_tb_top.sv ----
// self-checking bench for the connect control block
`timescale 1ns/1ps
`default_nettype none
module scan_port_address_connect_tb_top;
  import spac_pkg::*;
  localparam logic [9:0] BOARD = 10'h155;
  typedef struct {logic [9:0] a; spac_con_type st; logic ack;} spac_row_type;
  logic clk = 1'b0, arst_n = 1'b0, sec_in = 1'b0;
  logic tck_rise, pdi, pms, pdo, pdo_oe, sdo, sdo_oe, sms;
  logic [1:0] st;
  int n_mismatch = 0, compares = 0;
  spac_row_type rows [5] = '{'{BOARD, CON_ON, 1'b1}, '{10'h000, CON_RESET, 1'b0},
    '{10'h3FE, CON_OFF, 1'b0}, '{10'h3FF, CON_OFF, 1'b0}, '{10'h2AA, CON_OFF, 1'b0}};
  always #12.5 clk = ~clk;
  // far side data changes every cycle so a stale copy cannot match
  always @(negedge clk) sec_in <= ~sec_in;
  spac_master_model m_u (.i_clock(clk), .o_tck_rise(tck_rise), .o_data(pdi), .o_mode(pms));
  spac_connect dut_u (.i_clock(clk), .i_arst_n(arst_n), .i_tck_rise(tck_rise),
    .i_primary_data_in(pdi), .i_primary_mode_select(pms), .i_board_address_inputs(BOARD),
    .i_secondary_data_in(sec_in), .o_primary_data_out(pdo), .o_primary_data_out_oe(pdo_oe),
    .o_secondary_data_out(sdo), .o_secondary_data_out_oe(sdo_oe),
    .o_secondary_mode_select(sms), .o_connect_status(st));
  task automatic finish_test();
    if (n_mismatch == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  task automatic cmp1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp1
  task automatic cmp_st(input spac_con_type exp);
    #1;
    compares++;
    if (st !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, st, exp);
    end
  endtask : cmp_st
  // ack level k of 28: idle, select, ten pairs lsb first, select, idle
  function automatic logic ack_bit(input logic [9:0] a, input int k);
    if (k < 4) return k < 2;
    if (k >= 24) return k >= 26;
    return a[(k - 4) / 2] ? logic'((k - 4) % 2) : logic'(!((k - 4) % 2));
  endfunction : ack_bit
  task automatic sel_ack(input logic [9:0] a, input logic ack);
    m_u.send_select(a);
    if (ack) begin
      // each level is looked at while it stands, before the rise that samples it
      for (int k = 0; k < 28; k++) begin
        #1;
        cmp1(pdo_oe, 1'b1);
        cmp1(pdo, ack_bit(a, k));
        m_u.tck(1'b1, pms);
      end
    end
  endtask : sel_ack
  // watchdog against a hung run
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    cmp_st(CON_OFF);
    cmp1(sms, 1'b1);
    cmp1(pdo_oe | sdo_oe, 1'b0);
    arst_n = 1'b1;
    m_u.move(8'h00, 1);
    foreach (rows[i]) begin
      sel_ack(rows[i].a, rows[i].ack);
      cmp_st(rows[i].st);
      cmp1(pdo_oe, rows[i].ack);
      cmp1(sdo_oe, rows[i].ack);
      if (rows[i].st == CON_RESET) cmp1(sms, 1'b1);
    end
    sel_ack(BOARD, 1'b1);
    cmp_st(CON_ON);
    cmp1(pdo, sec_in);
    cmp1(sdo, pdi);
    cmp1(sms, pms);
    sel_ack(10'h3FE, 1'b0);
    cmp1(sms, 1'b0);
    // primary moves only after the chain is disconnected
    m_u.move(8'h05, 4);
    cmp1(sms, 1'b0);
    sel_ack(10'h3FF, 1'b0);
    cmp_st(CON_MULTI);
    cmp1(sdo_oe, 1'b1);
    cmp1(pdo_oe, 1'b0);
    m_u.move(8'h01, 2);
    sel_ack(10'h000, 1'b0);
    cmp_st(CON_MULTI);
    m_u.move(8'h03, 3);
    m_u.move(8'h03, 4);
    sel_ack(10'h000, 1'b0);
    cmp_st(CON_MULTI);
    m_u.move(8'h01, 2);
    sel_ack(BOARD, 1'b1);
    cmp_st(CON_ON);
    sel_ack(10'h3FF, 1'b0);
    cmp_st(CON_MULTI);
    // reset in mid-run drops multicast and raises secondary mode
    @(negedge clk);
    arst_n = 1'b0;
    cmp_st(CON_OFF);
    cmp1(sms, 1'b1);
    cmp1(sdo_oe | pdo_oe, 1'b0);
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    // mode kept high so the monitor stays in test-logic-reset
    m_u.move(8'h1F, 5);
    sel_ack(10'h3FF, 1'b0);
    cmp_st(CON_OFF);
    sel_ack(BOARD, 1'b1);
    cmp_st(CON_ON);
    cmp1(sms, pms);
    // address cut short after one bit drops the connection
    m_u.pair(1'b1, 1'b1);
    m_u.pair(1'b0, 1'b0);
    m_u.pair(1'b0, 1'b1);
    m_u.pair(1'b0, 1'b0);
    m_u.pair(1'b1, 1'b1);
    cmp_st(CON_OFF);
    cmp1(sdo_oe | pdo_oe, 1'b0);
    cmp1(sms, 1'b1);
    finish_test();
  end
endmodule : scan_port_address_connect_tb_top
`default_nettype wire

// ---- testbench/spac_master_model.sv ----
// bus master model driving the primary port: test clock pulses, select protocols, tap moves
`timescale 1ns/1ps
`default_nettype none
module spac_master_model (
  input  wire logic i_clock,
  output logic      o_tck_rise,
  output logic      o_data,
  output logic      o_mode
);
  // data line is driven high from the start, its idle level
  initial begin
    o_tck_rise = 1'b0;
    o_data     = 1'b1;
    o_mode     = 1'b1;
  end
  // one test clock period of four system cycles, levels set before the rise
  task automatic tck(input logic d, input logic m);
    @(negedge i_clock);
    o_data     = d;
    o_mode     = m;
    o_tck_rise = 1'b1;
    @(negedge i_clock);
    o_tck_rise = 1'b0;
    repeat (2) @(negedge i_clock);
  endtask : tck
  // mode held so the tap state stays put across a frame
  task automatic pair(input logic a, input logic b);
    tck(a, o_mode);
    tck(b, o_mode);
  endtask : pair
  task automatic send_select(input logic [9:0] addr);
    pair(1'b1, 1'b1);
    pair(1'b0, 1'b0);
    for (int i = 0; i < 10; i++) begin
      if (addr[i]) pair(1'b0, 1'b1);
      else pair(1'b1, 1'b0);
    end
    pair(1'b0, 1'b0);
    pair(1'b1, 1'b1);
  endtask : send_select
  // mode bits taken lsb first, one per test clock
  task automatic move(input logic [7:0] tms, input int n);
    for (int i = 0; i < n; i++) tck(1'b1, tms[i]);
  endtask : move
endmodule : spac_master_model
`default_nettype wire

// ---- verilog/spac_connect.sv ----
// connect control of the addressable scan port: tap monitor, select/ack, switching
`timescale 1ns/1ps
`default_nettype none
module spac_connect
  import spac_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_arst_n,
  input  wire logic       i_tck_rise,            // one-cycle enable on primary test clock rise
  input  wire logic       i_primary_data_in,
  input  wire logic       i_primary_mode_select,
  input  wire logic [9:0] i_board_address_inputs,
  input  wire logic       i_secondary_data_in,
  output logic            o_primary_data_out,
  output logic            o_primary_data_out_oe,
  output logic            o_secondary_data_out,
  output logic            o_secondary_data_out_oe,
  output logic            o_secondary_mode_select,
  output logic [1:0]      o_connect_status
);
  spac_tap_type tap_r, tap_nxt;
  spac_con_type con_r, con_nxt;
  spac_ph_type  ph_r, ph_nxt;
  logic         half_r, half_nxt;      // second bit of a pair pending
  logic         first_r, first_nxt;    // first bit of current pair
  logic [9:0]   addr_r, addr_nxt;
  logic [3:0]   cnt_r, cnt_nxt;
  logic         tms_hold_r, tms_hold_nxt;
  logic         ack_bit_r, ack_bit_nxt;

  wire logic tap_stable = (tap_r == TAP_RESET) || (tap_r == TAP_IDLE) ||
                          (tap_r == TAP_PAUSE_DR) || (tap_r == TAP_PAUSE_IR);
  wire logic tap_pause  = (tap_r == TAP_PAUSE_DR) || (tap_r == TAP_PAUSE_IR);

  // tap monitor mirrors the standard controller
  always_comb begin
    tap_nxt = tap_r;
    if (i_tck_rise) begin
      unique case (tap_r)
        TAP_RESET:    tap_nxt = i_primary_mode_select ? TAP_RESET    : TAP_IDLE;
        TAP_IDLE:     tap_nxt = i_primary_mode_select ? TAP_SEL_DR   : TAP_IDLE;
        TAP_SEL_DR:   tap_nxt = i_primary_mode_select ? TAP_SEL_IR   : TAP_CAP_DR;
        TAP_CAP_DR:   tap_nxt = i_primary_mode_select ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_SHIFT_DR: tap_nxt = i_primary_mode_select ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_EXIT1_DR: tap_nxt = i_primary_mode_select ? TAP_UPD_DR   : TAP_PAUSE_DR;
        TAP_PAUSE_DR: tap_nxt = i_primary_mode_select ? TAP_EXIT2_DR : TAP_PAUSE_DR;
        TAP_EXIT2_DR: tap_nxt = i_primary_mode_select ? TAP_UPD_DR   : TAP_SHIFT_DR;
        TAP_UPD_DR:   tap_nxt = i_primary_mode_select ? TAP_SEL_DR   : TAP_IDLE;
        TAP_SEL_IR:   tap_nxt = i_primary_mode_select ? TAP_RESET    : TAP_CAP_IR;
        TAP_CAP_IR:   tap_nxt = i_primary_mode_select ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_SHIFT_IR: tap_nxt = i_primary_mode_select ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_EXIT1_IR: tap_nxt = i_primary_mode_select ? TAP_UPD_IR   : TAP_PAUSE_IR;
        TAP_PAUSE_IR: tap_nxt = i_primary_mode_select ? TAP_EXIT2_IR : TAP_PAUSE_IR;
        TAP_EXIT2_IR: tap_nxt = i_primary_mode_select ? TAP_UPD_IR   : TAP_SHIFT_IR;
        TAP_UPD_IR:   tap_nxt = i_primary_mode_select ? TAP_SEL_DR   : TAP_IDLE;
      endcase
    end
  end

  // pair decode: idle 11, select 00, one 01, zero 10
  wire logic pair_done = i_tck_rise && half_r;
  wire logic p_idle    = first_r && i_primary_data_in;
  wire logic p_sel     = !first_r && !i_primary_data_in;
  wire logic p_one     = !first_r && i_primary_data_in;

  // protocol receive, evaluate and acknowledge sequencing
  always_comb begin
    ph_nxt      = ph_r;
    half_nxt    = half_r;
    first_nxt   = first_r;
    addr_nxt    = addr_r;
    cnt_nxt     = cnt_r;
    con_nxt     = con_r;
    ack_bit_nxt = ack_bit_r;
    if (i_tck_rise) begin
      half_nxt  = !half_r;
      first_nxt = i_primary_data_in;
      // pair framing resyncs on idle so a lone high bit cannot skew it
      if (!half_r && i_primary_data_in && ph_r == PH_IDLE) half_nxt = 1'b0;
    end
    if (i_tck_rise && !tap_stable && ph_r < PH_ACK_I) begin
      ph_nxt   = PH_IDLE;
      half_nxt = 1'b0;
    end else if (pair_done) begin
      unique case (ph_r)
        PH_IDLE:  if (p_sel) ph_nxt = PH_SEL1;
        PH_SEL1:  if (p_sel) begin
                    ph_nxt = PH_SEL1;
                  end else if (p_idle) begin
                    ph_nxt = PH_IDLE;
                  end else begin
                    addr_nxt = {p_one, addr_r[9:1]};
                    cnt_nxt  = 4'h1;
                    ph_nxt   = PH_DATA;
                  end
        PH_DATA:  if (p_sel && cnt_r == DATA_BITS) begin
                    ph_nxt = PH_SEL2;
                  end else if (!p_sel && !p_idle && cnt_r != DATA_BITS) begin
                    addr_nxt = {p_one, addr_r[9:1]};
                    cnt_nxt  = cnt_r + 4'h1;
                  end else begin
                    ph_nxt  = PH_IDLE; // length or framing error drops link
                    con_nxt = CON_OFF;
                  end
        PH_SEL2:  if (p_idle) begin
                    ph_nxt  = PH_IDLE;
                    con_nxt = CON_OFF;
                    if (addr_r == RESET_ADDR) begin
                      con_nxt = CON_RESET;
                    end else if (addr_r == TEST_SYNC_ADDR) begin
                      if (tap_pause) con_nxt = CON_MULTI;
                    end else if (addr_r == DISCONNECT_ADDR) begin
                      con_nxt = CON_OFF;
                    end else if (addr_r == i_board_address_inputs) begin
                      ph_nxt   = PH_ACK_I;
                      cnt_nxt  = 4'h0;
                      half_nxt = 1'b0;
                    end
                  end else begin
                    ph_nxt = PH_IDLE;
                  end
        default:  ;
      endcase
    end
    // acknowledge ISDDDDDDDDDDSI, one level per test clock rise
    if (i_tck_rise && ph_r >= PH_ACK_I) begin
      half_nxt = !half_r;
      unique case (ph_r)
        PH_ACK_I: begin
          if (half_r) ph_nxt = PH_ACK_S;
        end
        PH_ACK_S: begin
          if (half_r) ph_nxt = PH_ACK_D;
        end
        PH_ACK_D: begin
          if (half_r) begin
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r == DATA_BITS - 4'h1) ph_nxt = PH_ACK_E;
          end
        end
        PH_ACK_E: begin
          if (half_r && cnt_r == DATA_BITS) begin
            cnt_nxt  = 4'h0;
            half_nxt = 1'b0;
          end else if (half_r) begin
            ph_nxt   = PH_IDLE; // closing idle done
            half_nxt = 1'b0;
            con_nxt  = CON_ON;
          end
        end
        default: ;
      endcase
    end
    // level for the coming rise is set one period ahead, so the master
    // samples all 28 levels before the switch closes
    unique case (ph_nxt)
      PH_ACK_I: ack_bit_nxt = 1'b1;
      PH_ACK_S: ack_bit_nxt = 1'b0;
      PH_ACK_D: ack_bit_nxt = half_nxt ? addr_r[cnt_nxt] : !addr_r[cnt_nxt];
      PH_ACK_E: ack_bit_nxt = (cnt_nxt == 4'h0);
      default:  ack_bit_nxt = 1'b1;
    endcase
  end

  // last secondary mode level, held while off
  always_comb begin
    tms_hold_nxt = tms_hold_r;
    if (con_r == CON_ON || con_r == CON_MULTI) tms_hold_nxt = i_primary_mode_select;
    else if (con_r == CON_RESET) tms_hold_nxt = 1'b1;
  end

  // state registers
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tap_r      <= TAP_RESET;
      con_r      <= CON_OFF;
      ph_r       <= PH_IDLE;
      half_r     <= 1'b0;
      first_r    <= 1'b1;
      addr_r     <= 10'h000;
      cnt_r      <= 4'h0;
      tms_hold_r <= 1'b1;
      ack_bit_r  <= 1'b1;
    end else begin
      tap_r      <= tap_nxt;
      con_r      <= con_nxt;
      ph_r       <= ph_nxt;
      half_r     <= half_nxt;
      first_r    <= first_nxt;
      addr_r     <= addr_nxt;
      cnt_r      <= cnt_nxt;
      tms_hold_r <= tms_hold_nxt;
      ack_bit_r  <= ack_bit_nxt;
    end
  end

  // switch: routing follows connect status; ack overrides primary output
  wire logic acking = (ph_r >= PH_ACK_I);
  always_comb begin
    o_primary_data_out      = acking ? ack_bit_r : i_secondary_data_in;
    o_primary_data_out_oe   = acking || (con_r == CON_ON);
    o_secondary_data_out    = i_primary_data_in;
    o_secondary_data_out_oe = (con_r == CON_ON) || (con_r == CON_MULTI);
    unique case (con_r)
      CON_ON, CON_MULTI: o_secondary_mode_select = i_primary_mode_select;
      CON_RESET:         o_secondary_mode_select = 1'b1;
      default:           o_secondary_mode_select = tms_hold_r;
    endcase
  end
  assign o_connect_status = con_r;

  a_transit_ignored: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_tck_rise && !tap_stable && ph_r < PH_ACK_I) |=> ph_r == PH_IDLE)
    else $error("protocol kept in transit state");
  a_reset_addr_status: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (pair_done && ph_r == PH_SEL2 && p_idle && addr_r == RESET_ADDR) |=> con_r == CON_RESET)
    else $error("reset address not applied");
  a_disc_addr_off: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (pair_done && ph_r == PH_SEL2 && p_idle && addr_r == DISCONNECT_ADDR) |=> con_r == CON_OFF && !acking)
    else $error("disconnect address mishandled");
  a_sync_multicast: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (con_r != CON_MULTI) ##1 (con_r == CON_MULTI) |-> $past(tap_pause))
    else $error("multicast outside pause");
  a_match_acks: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (pair_done && ph_r == PH_SEL2 && p_idle && addr_r == i_board_address_inputs &&
     addr_r != RESET_ADDR && addr_r != TEST_SYNC_ADDR && addr_r != DISCONNECT_ADDR) |=> acking)
    else $error("match did not start acknowledge");
  a_on_after_ack: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (con_r != CON_ON) ##1 (con_r == CON_ON) |-> $past(ph_r) == PH_ACK_E)
    else $error("on without acknowledge");
  a_off_holds_mode: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (con_r == CON_OFF && $past(con_r) == CON_OFF) |-> $stable(o_secondary_mode_select))
    else $error("secondary mode moved while off");
  a_reset_mode_high: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    con_r == CON_RESET |-> o_secondary_mode_select && !o_secondary_data_out_oe && !o_primary_data_out_oe)
    else $error("reset status outputs wrong");
  c_match: cover property (@(posedge i_clock) con_r == CON_ON);
  c_multi: cover property (@(posedge i_clock) con_r == CON_MULTI);
  c_reset: cover property (@(posedge i_clock) con_r == CON_RESET);
endmodule : spac_connect
`default_nettype wire

// ---- verilog/spac_pkg.sv ----
// constants and types for the scan port address connect block
package spac_pkg;
  localparam int ADDR_W = 10;
  localparam logic [9:0] RESET_ADDR        = 10'h000;
  localparam logic [9:0] DISCONNECT_ADDR   = 10'h3FE;
  localparam logic [9:0] TEST_SYNC_ADDR    = 10'h3FF;
  localparam logic [3:0] DATA_BITS         = 4'hA;

  typedef enum logic [3:0] {
    TAP_RESET    = 4'h0, TAP_IDLE     = 4'h1, TAP_SEL_DR   = 4'h2, TAP_CAP_DR   = 4'h3,
    TAP_SHIFT_DR = 4'h4, TAP_EXIT1_DR = 4'h5, TAP_PAUSE_DR = 4'h6, TAP_EXIT2_DR = 4'h7,
    TAP_UPD_DR   = 4'h8, TAP_SEL_IR   = 4'h9, TAP_CAP_IR   = 4'hA, TAP_SHIFT_IR = 4'hB,
    TAP_EXIT1_IR = 4'hC, TAP_PAUSE_IR = 4'hD, TAP_EXIT2_IR = 4'hE, TAP_UPD_IR   = 4'hF
  } spac_tap_type;

  typedef enum logic [1:0] {
    CON_OFF = 2'h0, CON_ON = 2'h1, CON_RESET = 2'h2, CON_MULTI = 2'h3
  } spac_con_type;

  // receiver and transmitter phases
  typedef enum logic [2:0] {
    PH_IDLE = 3'h0, PH_SEL1 = 3'h1, PH_DATA = 3'h2, PH_SEL2 = 3'h3,
    PH_ACK_I = 3'h4, PH_ACK_S = 3'h5, PH_ACK_D = 3'h6, PH_ACK_E = 3'h7
  } spac_ph_type;
endpackage : spac_pkg
